// ===== shared/ddrb_port_regs.svh
// Overview of operation
// - The second beat of a burst uses the start address with only its lowest bit inverted.
// - A low load select with read/write select high at a true input clock edge starts a read at the given address.
// - A low load select with read/write select low at a true input clock edge starts a write at the given address.
// - A high load select starts nothing, read/write select is ignored and the data pins stay undriven.
// - Read beats leave the device one and a half and two input clock cycles after the command.
// - Write beats and their masks are taken four and four and a half input clock cycles after the command.
// - The controller finishes all work before halting the clocks; while halted the data pin outputs hold and commands are ignored.
// - In the narrow organisation two active-low masks gate the two low lanes per beat; both high abort the beat.
// - In the wide organisation four active-low masks gate four lanes per beat; all high abort the beat.
// - With the loop bypass pin low the loop is not locked and reads have one cycle of latency.
// - With both output timebase pins held high from power-up, read data is timed from the input clocks.
// - After a loop reset the device needs 2048 stable input clock cycles before normal operation.
`ifndef DDRB_PORT_REGS_SVH
`define DDRB_PORT_REGS_SVH

// ==========================================
// Organisation
`define DDRB_ADDR_W        8
`define DDRB_LANES         4
`define DDRB_LANE_W        9
`define DDRB_DATA_W        36

// ==========================================
// Timing in half input clock cycles, loop lock count in whole input clock cycles
`define DDRB_RD_FIRST_HALF 3
`define DDRB_RD_BYP_HALF   2
`define DDRB_WR_FIRST_HALF 8
`define DDRB_LOCK_CYCLES   2048
`define DDRB_LOCK_W        12

// ==========================================
// Reset values
`define DDRB_OE_RST        1'h0
`define DDRB_TIED_RST      1'h1
`define DDRB_CMD_RST       3'h4
`define DDRB_STRAP_RST     5'h0e

`endif

// ===== shared/ddrb_pkg.sv
`include "ddrb_port_regs.svh"

package ddrb_pkg;

  typedef struct packed {
    logic [`DDRB_ADDR_W:0]   addr;
    logic [`DDRB_DATA_W-1:0] data;
    logic [`DDRB_LANES-1:0]  maskN;
  } ddrb_wr_beat_t;

  typedef enum logic [2:0] {
    LOCK_WAIT  = 3'h1,
    LOCK_READY = 3'h2,
    LOCK_BYP   = 3'h4
  } ddrb_lock_t;

endpackage

// ===== hdl/ddrb_two_buf.sv
`timescale 1ns/1ps

module ddrb_two_buf
  import ddrb_pkg::*;
(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          resetn,
  // Fill side
  input  wire logic          inValid,
  output      logic          inReady,
  input  wire ddrb_wr_beat_t inData,
  // Drain side
  output      logic          outValid,
  input  wire logic          outReady,
  output      ddrb_wr_beat_t outData
);

  ddrb_wr_beat_t ent_q [2];
  logic          wp_q;
  logic          rp_q;
  logic [1:0]    cnt_q;
  wire           push = inValid & inReady;
  wire           pop  = outValid & outReady;

  assign inReady  = (cnt_q != 2'h2);
  assign outValid = (cnt_q != 2'h0);
  assign outData  = ent_q[rp_q];

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wp_q  <= 1'h0;
      rp_q  <= 1'h0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wp_q <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      cnt_q <= cnt_q + {1'h0, push} - {1'h0, pop};
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      ent_q[wp_q] <= inData;
    end
  end

endmodule

// ===== hdl/ddrb_sram_port.sv
`timescale 1ns/1ps
`include "ddrb_port_regs.svh"

module ddrb_sram_port
  import ddrb_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    resetn,
  // Command pins
  input  wire logic                    loadSelectN,
  input  wire logic                    readWriteSelect,
  input  wire logic                    burstStartLsb,
  input  wire logic [`DDRB_ADDR_W-1:0] addrIn,
  input  wire logic [`DDRB_LANES-1:0]  byteLaneWriteN,
  // Shared data pins
  input  wire logic [`DDRB_DATA_W-1:0] dqIn,
  output      logic [`DDRB_DATA_W-1:0] dqOut,
  output      logic                    dqOe,
  // Clocking and straps
  input  wire logic                    inClockRun,
  input  wire logic                    dllBypassN,
  input  wire logic                    outTimebaseP,
  input  wire logic                    outTimebaseN,
  input  wire logic                    orgHalf,
  // Status
  output      logic                    dllReady,
  output      logic                    timedFromInput,
  output      logic                    writeBufReady
);

  localparam int AW    = `DDRB_ADDR_W;
  localparam int SW    = 3 + AW + `DDRB_LANES + `DDRB_DATA_W + 5;
  localparam int DEPTH = 2 ** (AW + 1);
  localparam int RD1   = `DDRB_RD_FIRST_HALF - 2;
  localparam int RDB   = `DDRB_RD_BYP_HALF - 2;
  localparam int WR1   = `DDRB_WR_FIRST_HALF - 1;

  // ==========================================
  // Pin input synchronisers
  wire  [SW-1:0] pinRaw = {loadSelectN, readWriteSelect, burstStartLsb, addrIn, byteLaneWriteN, dqIn,
                           inClockRun, dllBypassN, outTimebaseP, outTimebaseN, orgHalf};
  // Idle pin levels, so no false command or strap change follows reset
  localparam logic [SW-1:0] PIN_RST  = {`DDRB_CMD_RST, {AW{1'h0}}, {`DDRB_LANES{1'h1}},
                                        {`DDRB_DATA_W{1'h0}}, `DDRB_STRAP_RST};
  // Beat data and masks change every half cycle, so they skip the agreement filter
  localparam logic [SW-1:0] PIN_FILT = {3'h7, {AW{1'h1}}, {`DDRB_LANES{1'h0}}, {`DDRB_DATA_W{1'h0}}, 5'h1f};
  logic [SW-1:0] s1_q;
  logic [SW-1:0] s2_q;
  logic [SW-1:0] s3_q;
  logic [SW-1:0] clean_q;

  genvar gi;
  generate
    for (gi = 0; gi < SW; gi++) begin : gSync
      always_ff @(posedge clk) begin
        if (!resetn) begin
          s1_q[gi]    <= PIN_RST[gi];
          s2_q[gi]    <= PIN_RST[gi];
          s3_q[gi]    <= PIN_RST[gi];
          clean_q[gi] <= PIN_RST[gi];
        end else begin
          s1_q[gi] <= pinRaw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (!PIN_FILT[gi]) begin
            clean_q[gi] <= s3_q[gi];
          end else if (s2_q[gi] == s3_q[gi]) begin
            clean_q[gi] <= s2_q[gi];
          end
        end
      end
    end
  endgenerate

  logic                    lsN;
  logic                    rwSel;
  logic                    lsb;
  logic [AW-1:0]           addrC;
  logic [`DDRB_LANES-1:0]  bwN;
  logic [`DDRB_DATA_W-1:0] din;
  logic                    run;
  logic                    bypN;
  logic                    otP;
  logic                    otN;
  logic                    half;

  assign {lsN, rwSel, lsb, addrC, bwN, din, run, bypN, otP, otN, half} = clean_q;

  // ==========================================
  // Half-cycle phase and command decode
  logic phase_q;
  wire  kRiseEn  = run & ~phase_q;
  wire  cmdLoad  = kRiseEn & ~lsN;
  wire  cmdRead  = cmdLoad & rwSel;
  wire  cmdWrite = cmdLoad & ~rwSel;
  wire  byp      = ~bypN;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      phase_q <= 1'h0;
    end else if (run) begin
      phase_q <= ~phase_q;
    end
  end

  // ==========================================
  // Operation slots, one shift per half cycle
  logic          rdV_q [0:2];
  logic [AW:0]   rdA_q [0:2];
  logic          wrV_q [0:8];
  logic [AW:0]   wrA_q [0:8];

  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int k = 0; k < 3; k++) begin
        rdV_q[k] <= 1'h0;
      end
      for (int k = 0; k < 9; k++) begin
        wrV_q[k] <= 1'h0;
      end
    end else if (run) begin
      rdV_q[0] <= cmdRead;
      wrV_q[0] <= cmdWrite;
      for (int k = 1; k < 3; k++) begin
        rdV_q[k] <= rdV_q[k-1];
      end
      for (int k = 1; k < 9; k++) begin
        wrV_q[k] <= wrV_q[k-1];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (run) begin
      rdA_q[0] <= {addrC, lsb};
      wrA_q[0] <= {addrC, lsb};
      for (int k = 1; k < 3; k++) begin
        rdA_q[k] <= rdA_q[k-1];
      end
      for (int k = 1; k < 9; k++) begin
        wrA_q[k] <= wrA_q[k-1];
      end
    end
  end

  // ==========================================
  // Read beat fetch
  wire          fetch1    = run & (byp ? rdV_q[RDB] : rdV_q[RD1]);
  wire          fetch2    = run & (byp ? rdV_q[RDB+1] : rdV_q[RD1+1]);
  wire          fetchAny  = fetch1 | fetch2;
  wire [AW:0]   rdSlot1   = byp ? rdA_q[RDB] : rdA_q[RD1];
  wire [AW:0]   rdSlot2   = byp ? rdA_q[RDB+1] : rdA_q[RD1+1];
  wire [AW:0]   fetchAddr = fetch2 ? {rdSlot2[AW:1], ~rdSlot2[0]} : rdSlot1;
  logic [`DDRB_DATA_W-1:0] rdWord;

  // ==========================================
  // Write beat capture
  wire                    sample1   = run & wrV_q[WR1];
  wire                    sample2   = run & wrV_q[WR1+1];
  wire [`DDRB_LANES-1:0]  bwEff     = half ? {2'h3, bwN[1:0]} : bwN;
  wire                    allMasked = &bwEff;
  wire [AW:0]             wrAddr    = sample2 ? {wrA_q[WR1+1][AW:1], ~wrA_q[WR1+1][0]} : wrA_q[WR1];
  wire                    bufInValid = (sample1 | sample2) & ~allMasked;
  ddrb_wr_beat_t          bufIn;
  ddrb_wr_beat_t          bufOut;
  logic                   bufOutValid;
  wire                    bufOutReady = ~fetchAny;
  wire                    commit      = bufOutValid & bufOutReady;

  assign bufIn = '{addr: wrAddr, data: din, maskN: bwEff};

  ddrb_two_buf uBuf (
    .clk      (clk),
    .resetn   (resetn),
    .inValid  (bufInValid),
    .inReady  (writeBufReady),
    .inData   (bufIn),
    .outValid (bufOutValid),
    .outReady (bufOutReady),
    .outData  (bufOut)
  );

  // ==========================================
  // Storage, one array per lane
  generate
    for (gi = 0; gi < `DDRB_LANES; gi++) begin : gLane
      logic [`DDRB_LANE_W-1:0] mem_q [DEPTH];
      wire  laneOff = half && (gi >= 2);
      always_ff @(posedge clk) begin
        if (commit && !bufOut.maskN[gi]) begin
          mem_q[bufOut.addr] <= bufOut.data[gi*`DDRB_LANE_W +: `DDRB_LANE_W];
        end
      end
      assign rdWord[gi*`DDRB_LANE_W +: `DDRB_LANE_W] = laneOff ? '0 : mem_q[fetchAddr];
    end
  endgenerate

  // ==========================================
  // Data pin drive
  logic [`DDRB_DATA_W-1:0] dqOut_q;
  logic                    dqOe_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      dqOe_q  <= `DDRB_OE_RST;
      dqOut_q <= '0;
    end else if (run) begin
      dqOe_q <= fetchAny;
      if (fetchAny) begin
        dqOut_q <= rdWord;
      end
    end
  end

  assign dqOut = dqOut_q;
  assign dqOe  = dqOe_q;

  // ==========================================
  // Loop lock tracking
  ddrb_lock_t              lock_q;
  logic [`DDRB_LOCK_W-1:0] lockCnt_q;
  logic                    tied_q;
  wire                     lockDone = kRiseEn && (lockCnt_q == `DDRB_LOCK_W'(`DDRB_LOCK_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (!resetn) begin
      lock_q    <= LOCK_WAIT;
      lockCnt_q <= '0;
    end else if (byp) begin
      lock_q    <= LOCK_BYP;
      lockCnt_q <= '0;
    end else begin
      case (lock_q)
        LOCK_BYP: begin
          lock_q    <= LOCK_WAIT;
          lockCnt_q <= '0;
        end
        LOCK_WAIT: begin
          if (lockDone) begin
            lock_q <= LOCK_READY;
          end else if (kRiseEn) begin
            lockCnt_q <= lockCnt_q + `DDRB_LOCK_W'(1);
          end
        end
        LOCK_READY: begin
          lock_q <= LOCK_READY;
        end
        default: begin
          lock_q <= LOCK_WAIT;
        end
      endcase
    end
  end

  // Output timebase tied high since the last reset
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tied_q <= `DDRB_TIED_RST;
    end else if (!otP || !otN) begin
      tied_q <= 1'h0;
    end
  end

  assign dllReady       = (lock_q == LOCK_READY) || (lock_q == LOCK_BYP);
  assign timedFromInput = tied_q;

  // ==========================================
  // Checks
  a_read_first_beat: assert property (@(posedge clk) disable iff (!resetn)
    (cmdRead && !byp) ##1 (run && !byp)[*2] |=> dqOe_q) else $error("first read beat late");
  a_read_second_beat: assert property (@(posedge clk) disable iff (!resetn)
    (cmdRead && !byp) ##1 (run && !byp)[*3] |=> dqOe_q) else $error("second read beat late");
  a_bypass_read_lat: assert property (@(posedge clk) disable iff (!resetn)
    (cmdRead && byp) ##1 (run && byp) |=> dqOe_q && $past(rdA_q[0]) == $past(fetchAddr)) else
    $error("bypass read latency wrong");
  a_idle_pins_hiz: assert property (@(posedge clk) disable iff (!resetn)
    run && !rdV_q[0] && !rdV_q[1] && !rdV_q[2] |=> !dqOe_q) else $error("pins driven without read");
  a_halt_holds_out: assert property (@(posedge clk) disable iff (!resetn)
    !run |=> $stable(dqOe_q) && $stable(dqOut_q)) else $error("outputs moved while halted");
  a_halt_ignores_cmd: assert property (@(posedge clk) disable iff (!resetn)
    !run |-> !cmdLoad ##1 !rdV_q[0] || !$past(run)) else $error("command taken while halted");
  a_burst_lsb_toggle: assert property (@(posedge clk) disable iff (!resetn)
    fetch1 ##1 fetch2 |-> fetchAddr == {$past(fetchAddr[AW:1]), ~$past(fetchAddr[0])}) else
    $error("second beat address wrong");
  a_write_beat_slot: assert property (@(posedge clk) disable iff (!resetn)
    cmdWrite ##1 run[*7] |=> wrV_q[WR1] && wrA_q[WR1] == $past({addrC, lsb}, 8)) else
    $error("write beat not sampled on time");
  a_abort_no_push: assert property (@(posedge clk) disable iff (!resetn)
    (sample1 || sample2) && allMasked |-> !bufInValid) else $error("aborted beat stored");
  a_lock_count_done: assert property (@(posedge clk) disable iff (!resetn)
    lock_q == LOCK_WAIT && lockDone && !byp |=> lock_q == LOCK_READY && dllReady) else
    $error("lock not reached");

  c_read_done: cover property (@(posedge clk) disable iff (!resetn) cmdRead ##[1:8] fetch2);
  c_write_done: cover property (@(posedge clk) disable iff (!resetn) cmdWrite ##[1:20] commit);
  c_abort_beat: cover property (@(posedge clk) disable iff (!resetn) sample1 && allMasked);
  c_bypass_read: cover property (@(posedge clk) disable iff (!resetn) cmdRead && byp);
  c_halt_read: cover property (@(posedge clk) disable iff (!resetn) rdV_q[0] ##1 !run);

endmodule

// ===== tb/ddrb_ctl_model.sv
`timescale 1ns/1ps
`include "ddrb_port_regs.svh"

module ddrb_ctl_model
  import ddrb_pkg::*;
(
  // Clock
  input  wire logic                    clk,
  // Command pins
  output      logic                    loadSelectN,
  output      logic                    readWriteSelect,
  output      logic                    burstStartLsb,
  output      logic [`DDRB_ADDR_W-1:0] addrIn,
  // Write beat pins
  output      logic [`DDRB_LANES-1:0]  byteLaneWriteN,
  output      logic [`DDRB_DATA_W-1:0] dqIn
);
  int cyc = 0;
  int off = 0;
  int par = 0;
  int k   = 0;

  initial begin
    loadSelectN     = 1'h1;
    readWriteSelect = 1'h1;
    burstStartLsb   = 1'h0;
    addrIn          = 8'h00;
    byteLaneWriteN  = 4'hf;
    dqIn            = 36'h000000000;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // ==========================================
  // One command, two cycles wide so one true edge sees it
  task automatic issue(input logic rd, input logic [`DDRB_ADDR_W-1:0] a, input logic lsb,
                       input logic [`DDRB_DATA_W-1:0] d1, input logic [`DDRB_DATA_W-1:0] d2,
                       input logic [`DDRB_LANES-1:0] m1, input logic [`DDRB_LANES-1:0] m2);
    step(1);
    while (cyc % 2 != par) step(1);
    k = cyc;
    loadSelectN     = 1'h0;
    readWriteSelect = rd;
    addrIn          = a;
    burstStartLsb   = lsb;
    step(2);
    loadSelectN     = 1'h1;
    readWriteSelect = ~rd;
    addrIn          = ~a;
    burstStartLsb   = ~lsb;
    if (!rd) begin
      step(k + off + 8 - cyc);
      dqIn           = d1;
      byteLaneWriteN = m1;
      step(1);
      dqIn           = d2;
      byteLaneWriteN = m2;
      step(1);
      // Released data pins show the inverse of the last beat; masks return all high
      dqIn           = ~dqIn;
      byteLaneWriteN = 4'hf;
    end
  endtask
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ps

module tb;
  localparam logic [35:0] D1 = 36'h123456789;
  localparam logic [35:0] D2 = 36'hfedcba987;
  localparam logic [35:0] F  = 36'hfffffffff;
  localparam logic [35:0] Z  = 36'h000000000;
  logic        clk = 1'h0;
  logic        resetn;
  logic        run;
  logic        bypN;
  logic        tbP;
  logic        tbN;
  logic        half;
  logic        ldN, rwSel, lsb, dqOe, dllReady, tfi, wbr;
  logic [7:0]  addr;
  logic [3:0]  bw;
  logic [35:0] dqIn, dqOut;
  int          mismatches = 0;
  int          checked = 0;
  int          cycles = 0;
  int          lat = 7;

  always #20 clk = ~clk;

  ddrb_ctl_model ctl (.clk(clk), .loadSelectN(ldN), .readWriteSelect(rwSel), .burstStartLsb(lsb),
    .addrIn(addr), .byteLaneWriteN(bw), .dqIn(dqIn));

  ddrb_sram_port DUT (.clk(clk), .resetn(resetn), .loadSelectN(ldN), .readWriteSelect(rwSel),
    .burstStartLsb(lsb), .addrIn(addr), .byteLaneWriteN(bw), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe),
    .inClockRun(run), .dllBypassN(bypN), .outTimebaseP(tbP), .outTimebaseN(tbN), .orgHalf(half),
    .dllReady(dllReady), .timedFromInput(tfi), .writeBufReady(wbr));

  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ==========================================
  // Read burst, judged beat by beat
  task automatic rd(input logic [7:0] a, input logic s, input logic [35:0] e1, input logic [35:0] e2);
    int n;
    ctl.issue(1'h1, a, s, Z, Z, 4'hf, 4'hf);
    n = 0;
    while (dqOe !== 1'h1 && n < 20) begin
      ctl.step(1);
      n++;
    end
    chk(36'(ctl.cyc - ctl.k - ctl.off), 36'(lat));
    chk(dqOut, e1);
    ctl.step(1);
    chk({dqOe, dqOut}, {1'h1, e2});
    ctl.step(1);
    chk(36'(dqOe), 36'h0);
  endtask

  task automatic t_calib();
    ctl.issue(1'h1, 8'h00, 1'h0, Z, Z, 4'hf, 4'hf);
    while (dqOe !== 1'h1 && ctl.cyc < ctl.k + 20) ctl.step(1);
    ctl.off = ctl.cyc - ctl.k - 7;
    chk(36'(ctl.off == 0 || ctl.off == 1), 36'h1);
    ctl.par = ctl.k % 2;
    ctl.step(4);
    $display("test calibrate done");
  endtask

  task automatic t_rw();
    ctl.issue(1'h0, 8'h5a, 1'h0, D1, D2, 4'h0, 4'h0);
    rd(8'h5a, 1'h0, D1, D2);
    rd(8'h5a, 1'h1, D2, D1);
    ctl.issue(1'h0, 8'h33, 1'h1, D1, D2, 4'h0, 4'h0);
    rd(8'h33, 1'h0, D2, D1);
    $display("test read write done");
  endtask

  task automatic t_mask();
    for (int i = 0; i < 4; i++) begin
      ctl.issue(1'h0, 8'h40 + 8'(i), 1'h0, F, F, 4'h0, 4'h0);
      ctl.issue(1'h0, 8'h40 + 8'(i), 1'h0, Z, Z, ~(4'h1 << i), 4'hf);
      rd(8'h40 + 8'(i), 1'h0, ~(36'h1ff << (9 * i)), F);
    end
    $display("test lanes done");
  endtask

  task automatic t_org();
    half = 1'h1;
    ctl.step(6);
    ctl.issue(1'h0, 8'h21, 1'h0, Z, Z, 4'h0, 4'h0);
    ctl.issue(1'h0, 8'h21, 1'h0, F, F, 4'h3, 4'hd);
    rd(8'h21, 1'h0, Z, 36'h00003fe00);
    half = 1'h0;
    ctl.step(6);
    $display("test narrow done");
  endtask

  task automatic t_nop();
    for (int i = 0; i < 16; i++) begin
      ctl.step(1);
      if (i % 2 == 0) begin
        ctl.readWriteSelect = ~ctl.readWriteSelect;
      end
      chk(36'(dqOe), 36'h0);
    end
    $display("test idle done");
  endtask

  task automatic t_freeze();
    rd(8'h5a, 1'h0, D1, D2);
    ctl.step(2);
    run = 1'h0;
    ctl.step(5);
    ctl.loadSelectN     = 1'h0;
    ctl.readWriteSelect = 1'h1;
    ctl.step(2);
    ctl.loadSelectN     = 1'h1;
    ctl.step(5);
    run = 1'h1;
    for (int i = 0; i < 16; i++) begin
      ctl.step(1);
      chk({dqOe, dqOut}, {1'h0, D2});
    end
    $display("test clock stop done");
  endtask

  task automatic t_lock();
    chk(36'(dllReady), 36'h0);
    while (dllReady !== 1'h1 && cycles < 6000) ctl.step(1);
    chk(36'(cycles > 4100), 36'h1);
    bypN = 1'h0;
    ctl.step(8);
    chk(36'(dllReady), 36'h1);
    lat = 6;
    rd(8'h5a, 1'h1, D2, D1);
    bypN = 1'h1;
    lat = 7;
    ctl.step(8);
    chk(36'(dllReady), 36'h0);
    $display("test loop done");
  endtask

  task automatic t_tied();
    chk(36'(tfi), 36'h1);
    chk(36'(wbr), 36'h1);
    tbP = 1'h0;
    ctl.step(6);
    tbP = 1'h1;
    ctl.step(2);
    chk(36'(tfi), 36'h0);
    resetn = 1'h0;
    ctl.step(5);
    resetn = 1'h1;
    ctl.step(6);
    chk({34'h0, tfi, dllReady}, 36'h2);
    tbN = 1'h0;
    ctl.step(6);
    tbN = 1'h1;
    ctl.step(2);
    chk(36'(tfi), 36'h0);
    $display("test timebase done");
  endtask

  initial begin
    resetn = 1'h0;
    run    = 1'h1;
    bypN   = 1'h1;
    tbP    = 1'h1;
    tbN    = 1'h1;
    half   = 1'h0;
    ctl.step(5);
    resetn = 1'h1;
    ctl.step(1);
    chk({32'h0, dqOe, wbr, tfi, dllReady}, 36'h6);
    ctl.step(6);
    t_calib();
    t_rw();
    t_mask();
    t_org();
    t_nop();
    t_freeze();
    t_lock();
    t_tied();
    report_and_stop();
  end
endmodule
